/* File: src/shp_top.v */
// serial host port with interrupt pin and general purpose pins
`include "shp_defs.vh"

// Operation
// - each gpio pin direction comes from gpio register bits 1 and 0.
// - input gpio pins show their sensed level in bits 3 and 2.
// - output gpio pins drive the level written to bits 3 and 2.
// - low reset pin resets all; internal reset sequence ends within 2 us.
// - interrupt pin asserts while any unmasked source is pending.
// - global config bits 3..2 pick interrupt drive style and active level.
// - address then data bits on serial_in are taken on rising shift clock.
// - serial_out changes on falling shift clock edges.
module shp_top #(
    parameter RST_CYC = `SHP_RST_CYC
) (
    input  wire       core_clk,
    input  wire       rst_n,
    input  wire       cs_n,
    input  wire       sclk,
    input  wire       serial_in,
    output reg        serial_out,
    output reg        serial_out_oe,
    input  wire [1:0] gpio_in,
    output reg  [1:0] gpio_out,
    output reg  [1:0] gpio_oe,
    input  wire [7:0] int_src,
    output reg        int_out,
    output reg        int_oe,
    output reg        ready
);
    // *****************************************************************
    // pin synchronisers
    // *****************************************************************
    // pins enter lsb first: sclk, serial_in, select, gpio, sources
    wire [12:0] pins_s;
    shp_sync #(.W(13)) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .d        ({int_src, gpio_in, ~cs_n, serial_in, sclk}),
        .q        (pins_s)
    );
    // cs_n inverted through the synchroniser so reset reads as deselected
    wire       sclk_s = pins_s[0];
    wire       sel_s  = pins_s[2];
    wire       din_s  = pins_s[1];
    wire [1:0] gpi_s  = pins_s[4:3];
    wire [7:0] src_s  = pins_s[12:5];

    reg        sclk_d_reg;
    reg        sel_d_reg;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d_reg <= 1'b0;
            sel_d_reg  <= 1'b0;
        end else begin
            sclk_d_reg <= sclk_s;
            sel_d_reg  <= sel_s;
        end
    end
    wire sclk_rise = sclk_s & ~sclk_d_reg;
    wire sclk_fall = ~sclk_s & sclk_d_reg;
    wire sel_start = sel_s & ~sel_d_reg;

    // *****************************************************************
    // reset sequence
    // *****************************************************************
    // held off until the counter reaches RST_CYC - 2; ready rises one cycle inside the 2 us bound
    reg [15:0] rst_cnt_reg;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_cnt_reg <= 16'h0000;
            ready       <= 1'b0;
        end else if (!ready) begin
            rst_cnt_reg <= rst_cnt_reg + 16'h0001;
            if (rst_cnt_reg >= RST_CYC[15:0] - 16'h0002)
                ready <= 1'b1;
        end
    end

    // *****************************************************************
    // serial frame: r/w bit, 7 address bits, 8 data bits
    // *****************************************************************
    localparam ST_IDLE = 3'b001;
    localparam ST_ADDR = 3'b010;
    localparam ST_DATA = 3'b100;

    reg [2:0]  st_reg;
    reg [3:0]  bit_cnt_reg;
    reg [7:0]  shift_reg;
    reg        rd_reg;
    reg [6:0]  addr_reg;
    reg [7:0]  tx_reg;
    reg [7:0]  gpio_reg;
    reg [7:0]  global_config_reg;
    reg [7:0]  mask_reg;
    reg [7:0]  pend_reg;
    reg        wr_stb;

    wire [7:0] gpio_rd = {gpio_reg[7:4],
        (gpio_reg[1] ? gpio_reg[3] : gpi_s[1]),
        (gpio_reg[0] ? gpio_reg[2] : gpi_s[0]),
        gpio_reg[1:0]};

    function [7:0] rd_mux;
        input [6:0] a;
        begin
            case (a)
                `SHP_ADDR_GPIO:     rd_mux = gpio_rd;
                `SHP_ADDR_GLB_CFG:  rd_mux = global_config_reg;
                `SHP_ADDR_INT_MASK: rd_mux = mask_reg;
                `SHP_ADDR_INT_STAT: rd_mux = pend_reg;
                default:            rd_mux = 8'h00;
            endcase
        end
    endfunction

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg      <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg   <= 8'h00;
            rd_reg      <= 1'b0;
            addr_reg    <= 7'h00;
            tx_reg      <= 8'h00;
            wr_stb      <= 1'b0;
        end else begin
            wr_stb <= 1'b0;
            if (!sel_s || !ready) begin
                st_reg <= ST_IDLE;
            end else if (sel_start) begin
                st_reg      <= ST_ADDR;
                bit_cnt_reg <= 4'h0;
            end else if (sclk_rise) begin
                shift_reg   <= {shift_reg[6:0], din_s};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                case (st_reg)
                    ST_ADDR: begin
                        if (bit_cnt_reg == 4'h7) begin
                            rd_reg      <= shift_reg[6];
                            addr_reg    <= {shift_reg[5:0], din_s};
                            tx_reg      <= rd_mux({shift_reg[5:0], din_s});
                            bit_cnt_reg <= 4'h0;
                            st_reg      <= ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        if (bit_cnt_reg == 4'h7) begin
                            wr_stb <= ~rd_reg;
                            st_reg <= ST_IDLE; // one byte per access
                        end
                    end
                    default: st_reg <= ST_IDLE;
                endcase
            end else if (sclk_fall && st_reg == ST_DATA && rd_reg && bit_cnt_reg != 4'h0) begin
                tx_reg <= {tx_reg[6:0], 1'b0};
            end
        end
    end

    // *****************************************************************
    // serial output, read data msb first
    // *****************************************************************
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_out    <= 1'b0;
            serial_out_oe <= 1'b0;
        end else begin
            serial_out_oe <= sel_s & ready;
            if (sclk_fall && st_reg == ST_DATA && rd_reg)
                serial_out <= (bit_cnt_reg == 4'h0) ? tx_reg[7] : tx_reg[6];
        end
    end

    // *****************************************************************
    // registers, written at the end of a write frame
    // *****************************************************************
    wire [7:0] wdata = shift_reg;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gpio_reg          <= `SHP_GPIO_RST;
            global_config_reg <= `SHP_GLB_CFG_RST;
            mask_reg          <= `SHP_MASK_RST;
            pend_reg          <= 8'h00;
        end else begin
            if (wr_stb && addr_reg == `SHP_ADDR_GPIO)
                gpio_reg <= wdata;
            if (wr_stb && addr_reg == `SHP_ADDR_GLB_CFG)
                global_config_reg <= wdata;
            if (wr_stb && addr_reg == `SHP_ADDR_INT_MASK)
                mask_reg <= wdata;
            // write one to clear; a new event in the same cycle wins
            if (wr_stb && addr_reg == `SHP_ADDR_INT_STAT)
                pend_reg <= (pend_reg & ~wdata) | src_s;
            else
                pend_reg <= pend_reg | src_s;
        end
    end

    // *****************************************************************
    // pins: gpio and interrupt
    // *****************************************************************
    wire irq = |(pend_reg & ~mask_reg);
    wire pp  = global_config_reg[`SHP_GLB_CFG_INT_PP];
    wire ahi = global_config_reg[`SHP_GLB_CFG_INT_HI];
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gpio_out <= 2'b00;
            gpio_oe  <= 2'b00;
            int_out  <= 1'b0;
            int_oe   <= 1'b0;
        end else begin
            gpio_oe  <= gpio_reg[`SHP_GPIO_DIR_LO+1:`SHP_GPIO_DIR_LO];
            gpio_out <= gpio_reg[`SHP_GPIO_LVL_LO+1:`SHP_GPIO_LVL_LO];
            // open drain only pulls toward the active level
            int_out  <= irq ~^ ahi;
            int_oe   <= pp | irq;
        end
    end
endmodule // shp_top

/* File: src/shp_defs.vh */
// constants for the serial host port block
`ifndef SHP_DEFS_VH
`define SHP_DEFS_VH
// *****************************************************************
// register addresses (7-bit address space)
// *****************************************************************
`define SHP_ADDR_W          7
`define SHP_ADDR_GPIO       7'h01
`define SHP_ADDR_GLB_CFG    7'h02
`define SHP_ADDR_INT_MASK   7'h03
`define SHP_ADDR_INT_STAT   7'h04
// *****************************************************************
// field positions and reset values
// *****************************************************************
`define SHP_GPIO_DIR_LO     0
`define SHP_GPIO_LVL_LO     2
`define SHP_GLB_CFG_INT_LO  2
`define SHP_GLB_CFG_INT_PP  2
`define SHP_GLB_CFG_INT_HI  3
`define SHP_GPIO_RST        8'h00
`define SHP_GLB_CFG_RST     8'h00
`define SHP_MASK_RST        8'hff
// *****************************************************************
// timing
// *****************************************************************
`define SHP_CLK_MHZ         50
`define SHP_RST_MAX_NS      2000
`define SHP_RST_CYC         ((`SHP_RST_MAX_NS * `SHP_CLK_MHZ) / 1000)
`endif

/* File: src/shp_sync.v */
// two flip-flop synchroniser for pin inputs
module shp_sync #(
    parameter W = 1
) (
    input  wire         core_clk,
    input  wire         rst_n,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= {W{1'b0}};
            sync_reg <= {W{1'b0}};
        end else begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;
endmodule // shp_sync

/* File: tb/shp_host.sv */
// host model driving framed serial accesses
module shp_host (
    input  wire logic core_clk,
    output logic      cs_n = 1'b1,
    output logic      sclk = 1'b0,
    output logic      serial_in = 1'b0,
    input  wire logic serial_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // sel high frames it (cs_n low); w is {rw, addr, data}; 160 ns shift clock
    task automatic xfer(input logic sel, input logic [15:0] w, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge core_clk);
        cs_n <= ~sel;
        repeat (4) @(posedge core_clk);
        for (int i = 15; i >= 0; i--) begin
            serial_in <= w[i];
            repeat (4) @(posedge core_clk);
            sclk <= 1'b1;
            // read data launched on the last fall must already stand at this rise
            if (i < 8) rd[i] = serial_out;
            repeat (4) @(posedge core_clk);
            sclk <= 1'b0;
        end
        repeat (8) @(posedge core_clk);
        cs_n      <= 1'b1;
        serial_in <= ~w[0];  // released line must not echo the last bit
        repeat (8) @(negedge core_clk);
    endtask
endmodule // shp_host

/* File: tb/shp_top_chk.sv */
// pin-level assertions for the serial host port
module shp_top_chk #(
    parameter RST_CYC = 100
) (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       cs_n,
    input wire logic       sclk,
    input wire logic       serial_out,
    input wire logic       serial_out_oe,
    input wire logic [1:0] gpio_out,
    input wire logic [1:0] gpio_oe,
    input wire logic       int_oe,
    input wire logic       ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] up_cnt_reg;
    always_ff @(posedge core_clk or negedge rst_n)
        if (!rst_n) up_cnt_reg <= 8'h00;
        else if (up_cnt_reg != 8'hff) up_cnt_reg <= up_cnt_reg + 8'h01;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_ready_in_time: assert property (up_cnt_reg >= RST_CYC |-> ready)
        else $error("reset sequence too long");
    a_int_quiet: assert property (!ready |-> !int_oe)
        else $error("irq driven before ready");
    a_pins_frozen: assert property (cs_n [*8] |-> $stable(gpio_oe) && $stable(gpio_out))
        else $error("gpio moved without access");
    a_dir_in_frame: assert property ($changed(gpio_oe) |-> !cs_n)
        else $error("gpio direction changed outside frame");
    a_out_on_fall: assert property (
        serial_out_oe && $past(serial_out_oe) && $changed(serial_out) |-> !$past(sclk, 2))
        else $error("serial_out moved off a falling edge");
    a_oe_needs_cs: assert property ($rose(serial_out_oe) |-> !cs_n && !$past(cs_n, 2))
        else $error("serial_out driven without select");
    a_oe_release: assert property ($rose(cs_n) |-> ##[1:6] !serial_out_oe)
        else $error("serial_out not released");
    a_oe_idle: assert property (cs_n [*5] |-> !serial_out_oe)
        else $error("serial_out driven while idle");
endmodule // shp_top_chk
bind shp_top shp_top_chk #(.RST_CYC(RST_CYC)) chk (.core_clk(core_clk), .rst_n(rst_n),
    .cs_n(cs_n), .sclk(sclk), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .int_oe(int_oe), .ready(ready));

/* File: tb/shp_top_tb.sv */
// self-checking bench for the serial host port
`include "shp_defs.vh"
module shp_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RC = 4;  // short reset sequence keeps the run brief
    logic       core_clk = 1'b0, rst_n = 1'b0, cs_n, sclk, serial_in, serial_out;
    logic       serial_out_oe, int_out, int_oe, ready;
    logic [1:0] gpio_in = 2'b00, gpio_out, gpio_oe;
    logic [7:0] int_src = 8'h00, r;
    int         err_total = 0, n_tests = 0, cyc = 0;
    shp_top #(.RST_CYC(RC)) uut (.core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .int_src(int_src),
        .int_out(int_out), .int_oe(int_oe), .ready(ready));
    shp_host host (.core_clk(core_clk), .cs_n(cs_n), .sclk(sclk), .serial_in(serial_in),
        .serial_out(serial_out_oe ? serial_out : ~serial_out));
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            stop_test();
        end
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.xfer(1'b1, {1'b0, a, d}, r);
    endtask
    task automatic rd(input logic [6:0] a);
        host.xfer(1'b1, {1'b1, a, 8'h00}, r);
    endtask
    task automatic t_reset;
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        check({3'h0, ready, int_oe, serial_out_oe, gpio_oe}, 8'h00);
        repeat (RC) @(negedge core_clk);
        check({7'h00, ready}, 8'h01);
    endtask
    task automatic t_gpio;
        wr(`SHP_ADDR_GPIO, 8'h0d);
        check({5'h00, gpio_out[0], gpio_oe}, 8'h05);
        @(posedge core_clk);
        gpio_in <= 2'b10;
        rd(`SHP_ADDR_GPIO);
        check({4'h0, r[3:0]}, 8'h0d);
        check({7'h00, serial_out_oe}, 8'h00);
        wr(`SHP_ADDR_GPIO, 8'h02);
        check({5'h00, gpio_out[1], gpio_oe}, 8'h02);
        @(posedge core_clk);
        gpio_in <= 2'b01;
        rd(`SHP_ADDR_GPIO);
        check({4'h0, r[3:0]}, 8'h06);
    endtask
    task automatic t_ignore;
        host.xfer(1'b0, {1'b0, `SHP_ADDR_GPIO, 8'h01}, r);
        check({6'h00, gpio_oe}, 8'h02);
    endtask
    task automatic t_int;
        @(posedge core_clk);
        int_src <= 8'h01;
        wr(`SHP_ADDR_GLB_CFG, 8'h0c);
        check({6'h00, int_oe, int_out}, 8'h02);
        wr(`SHP_ADDR_INT_MASK, 8'hfe);
        check({6'h00, int_oe, int_out}, 8'h03);
        @(posedge core_clk);
        int_src <= 8'h00;
        wr(`SHP_ADDR_INT_STAT, 8'h01);
        check({6'h00, int_oe, int_out}, 8'h02);
        wr(`SHP_ADDR_GLB_CFG, 8'h00);
        check({7'h00, int_oe}, 8'h00);
        @(posedge core_clk);
        int_src <= 8'h02;
        repeat (6) @(negedge core_clk);
        check({7'h00, int_oe}, 8'h00);
        @(posedge core_clk);
        int_src <= 8'h01;
        repeat (6) @(negedge core_clk);
        check({6'h00, int_oe, int_out}, 8'h02);
    endtask
    initial begin
        t_reset();
        t_gpio();
        t_ignore();
        t_int();
        t_reset();
        stop_test();
    end
endmodule // shp_top_tb
